// >>> design/pbs_debounce.sv
/*
  Shared constants for the push-button and standby input block, and the
  two-edge debounce filter that the main module instantiates.
  Assumes a synchronised input level and a one-cycle millisecond tick,
  both on ref_clk.
*/
package pbs_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned MS_CYCLES_DEF = CLK_HZ / 1000;
  localparam int unsigned DISCHARGE_US = 30;
  localparam int unsigned DISCHARGE_CYC =
    (DISCHARGE_US * (CLK_HZ / 1000000) + 0) > 0 ?
    DISCHARGE_US * (CLK_HZ / 1000000) : 1;
  localparam int unsigned DISCH_W = 10;
  // Debounce times in ms
  localparam logic [9:0] DBNC_SHORT_MS = 10'd32;
  localparam logic [9:0] DBNC_MID_MS = 10'd125;
  localparam logic [9:0] DBNC_LONG_MS = 10'd750;
  localparam int unsigned DBNC_W = 10;
  // Hold times in ms
  localparam int unsigned HOLD_W = 14;
  localparam logic [13:0] HOLD_1S_MS = 14'd1000;
  localparam logic [13:0] HOLD_2S_MS = 14'd2000;
  localparam logic [13:0] HOLD_3S_MS = 14'd3000;
  localparam logic [13:0] HOLD_4S_MS = 14'd4000;
  localparam logic [13:0] HOLD_8S_MS = 14'd8000;
  localparam logic [13:0] HOLD_16S_MS = 14'd16000;
  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  // Control field positions
  localparam int unsigned CTRL_DBNC_LSB = 0;
  localparam int unsigned CTRL_HOLD_LSB = 2;
  localparam int unsigned CTRL_RSTEN_BIT = 4;
  localparam int unsigned CTRL_STBYPOL_BIT = 5;
  // Interrupt latch positions
  localparam int unsigned N_IRQ = 7;
  localparam int unsigned IRQ_PRESS = 0;
  localparam int unsigned IRQ_REL = 1;
  localparam int unsigned IRQ_HOLD0 = 2;
  localparam int unsigned N_HOLD = 5;
  // Reset values
  localparam logic [6:0] MASK_RST = 7'h7F;
  // Reset sequence states, Gray along the path
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_PDOWN = 2'b01,
    SEQ_DISCH = 2'b11,
    SEQ_PUP = 2'b10
  } pbs_seq_type;

  // Falling edge debounce from the select code
  function automatic logic [9:0] fallMs(input logic [1:0] sel);
    case (sel)
      2'b10: fallMs = DBNC_MID_MS;
      2'b11: fallMs = DBNC_LONG_MS;
      default: fallMs = DBNC_SHORT_MS;
    endcase
  endfunction

  // Hold delay before reset or turn-off
  function automatic logic [13:0] holdDelayMs(input logic [1:0] sel);
    case (sel)
      2'b00: holdDelayMs = HOLD_2S_MS;
      2'b01: holdDelayMs = HOLD_4S_MS;
      2'b10: holdDelayMs = HOLD_8S_MS;
      default: holdDelayMs = HOLD_16S_MS;
    endcase
  endfunction

  // Long-hold interrupt thresholds by index
  function automatic logic [13:0] holdIrqMs(input int unsigned i);
    case (i)
      0: holdIrqMs = HOLD_1S_MS;
      1: holdIrqMs = HOLD_2S_MS;
      2: holdIrqMs = HOLD_3S_MS;
      3: holdIrqMs = HOLD_4S_MS;
      default: holdIrqMs = HOLD_8S_MS;
    endcase
  endfunction
endpackage

`timescale 1ns/1ps
module pbs_debounce (
  input wire logic ref_clk, // Internal clock
  input wire logic rst_b, // Async reset, active low
  input wire logic levelIn, // Synchronised raw level
  input wire logic msTick, // One pulse per millisecond
  input wire logic [9:0] fallLimit, // Low time to accept, ms
  input wire logic [9:0] riseLimit, // High time to accept, ms
  output logic levelOut, // Debounced level
  output logic fellPulse, // Debounced fall, one cycle
  output logic rosePulse // Debounced rise, one cycle
);
  typedef struct packed {
    logic level; // Accepted level
    logic [9:0] cnt; // Ms the raw level has differed
    logic fell; // Fall pulse
    logic rose; // Rise pulse
  } pbs_dbnc_type;

  pbs_dbnc_type q, d;

  // Count only while raw differs; any return restarts the wait
  always_comb begin
    d = q;
    d.fell = 1'b0;
    d.rose = 1'b0;
    if (levelIn == q.level) begin
      d.cnt = '0;
    end else if (msTick) begin
      if ((q.cnt + 10'd1) >= (q.level ? fallLimit : riseLimit)) begin
        d.level = levelIn;
        d.cnt = '0;
        d.fell = ~levelIn;
        d.rose = levelIn;
      end else begin
        d.cnt = q.cnt + 10'd1;
      end
    end
  end

  // Released button idles high
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{level: 1'b1, cnt: '0, fell: 1'b0, rose: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign levelOut = q.level;
  assign fellPulse = q.fell;
  assign rosePulse = q.rose;
endmodule

// >>> design/pbs_button_standby.sv
/*
  Power-on button and standby input conditioning with its small register
  file, interrupt latches and the button-forced chip reset sequence.
  Assumes the power state machine outside consumes the request outputs
  and answers a power-down request with powerDownDone.
*/
// How it works
// - pin mode 0 means level sensitive input
// - level mode: low holds off, high permits
// - pin mode 1 means push button, low pressed
// - level sense reads 1 when pin low
// - two-bit debounce select, rise fixed 32 ms
// - debounce select loaded from fuse default
// - debounced press starts power-on, raises interrupts
// - system on: debounced low sets press latch
// - system on: debounced high sets release latch
// - hold latches at 1, 2, 3, 4, 8 s
// - reset enabled: hold delay forces chip reset
// - reset: power down, wait 30 us, power up
// - reset disabled: hold delay starts turn-off
// - hold delay select loaded from fuse default
// - standby follows the active standby request
// - standby request is pin xor polarity
// - latches stay until software writes one
// - interrupt low while unmasked latch set
`timescale 1ns/1ps
module pbs_button_standby #(
  parameter int unsigned MS_CYCLES = pbs_pkg::MS_CYCLES_DEF
) (
  input wire logic ref_clk, // Internal clock, 20 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic power_on_input, // Power-on pin, async
  input wire logic standby_pin, // Standby pin, async
  input wire logic otp_on_pin_mode_cfg, // Fuse: 1 edge, 0 level
  input wire logic [1:0] otp_button_debounce_default, // Fuse default
  input wire logic [1:0] otp_hold_delay_default, // Fuse default
  input wire logic sysOn, // System-on states
  input wire logic powerDownDone, // Power-down finished
  input wire logic [7:0] regAddr, // Register byte address
  input wire logic [7:0] regWdata, // Write data
  input wire logic regWrite, // Write strobe
  input wire logic regRead, // Read strobe
  output logic [7:0] regRdata, // Read data, cycle after strobe
  output logic irq_out_n, // Interrupt, active low
  output logic offModeHold, // Level mode, pin low
  output logic powerOnLevelOk, // Level mode, pin high
  output logic powerOnEvent, // Power-on event pulse
  output logic turnOffReq, // Turn-off event pulse
  output logic powerDownReq, // Chip reset power-down level
  output logic powerUpReq, // Chip reset power-up pulse
  output logic standbyReq // Standby requested
);
  localparam int unsigned PW = $clog2(MS_CYCLES);
  localparam logic [PW-1:0] TICK_LAST = PW'(MS_CYCLES - 1);
  localparam logic [9:0] DISCH_LAST = 10'(pbs_pkg::DISCHARGE_CYC - 1);

  // The tick counter needs at least two states
  if (MS_CYCLES < 2) begin
    $error("MS_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic onS1;
    logic onS2;
    logic sbS1;
    logic sbS2;
    logic lvlPrev;
    logic [PW-1:0] prescale;
    logic msTick;
    logic [13:0] holdMs;
    logic [1:0] dbncSel;
    logic [1:0] holdSel;
    logic rstEn;
    logic stbyPol;
    logic otpLoaded;
    logic [6:0] intr;
    logic [6:0] mask;
    logic [7:0] rdata;
    logic irqN;
    logic offHold;
    logic lvlOk;
    logic onEvt;
    logic offEvt;
    logic stby;
    pbs_pkg::pbs_seq_type seq; // Chip reset sequence
    logic [9:0] dischCnt; // Discharge wait cycles
    logic puReq; // Power-up pulse
  } pbs_state_type;

  pbs_state_type q, d;
  logic btnLevel; // Debounced pin level
  logic btnFell; // Debounced press
  logic btnRose; // Debounced release
  logic holdFire; // Hold delay reached
  logic [6:0] setv; // Latch set events
  logic [6:0] clrv; // Latch clear from software
  logic wrCtrl; // Control write
  logic wrInt; // Latch write
  logic wrMask; // Mask write

  // Debounce on the synced level only; rise is always short
  pbs_debounce u_dbnc (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .levelIn(q.onS2),
    .msTick(q.msTick),
    .fallLimit(pbs_pkg::fallMs(q.dbncSel)),
    .riseLimit(pbs_pkg::DBNC_SHORT_MS),
    .levelOut(btnLevel),
    .fellPulse(btnFell),
    .rosePulse(btnRose)
  );

  assign wrCtrl = regWrite && (regAddr == pbs_pkg::ADDR_CTRL);
  assign wrInt = regWrite && (regAddr == pbs_pkg::ADDR_INT);
  assign wrMask = regWrite && (regAddr == pbs_pkg::ADDR_MASK);

  // All next-state logic
  always_comb begin
    d = q;
    setv = '0;
    holdFire = 1'b0;
    // Two flops on each pin before anything looks at it
    d.onS1 = power_on_input;
    d.onS2 = q.onS1;
    d.sbS1 = standby_pin;
    d.sbS2 = q.sbS1;
    // Fixed millisecond time base, independent of bus activity
    d.msTick = 1'b0;
    if (q.prescale == TICK_LAST) begin
      d.prescale = '0;
      d.msTick = 1'b1;
    end else begin
      d.prescale = q.prescale + 1'b1;
    end
    // Control register write
    if (wrCtrl) begin
      d.dbncSel = regWdata[pbs_pkg::CTRL_DBNC_LSB +: 2];
      d.holdSel = regWdata[pbs_pkg::CTRL_HOLD_LSB +: 2];
      d.rstEn = regWdata[pbs_pkg::CTRL_RSTEN_BIT];
      d.stbyPol = regWdata[pbs_pkg::CTRL_STBYPOL_BIT];
    end
    // Fuse defaults win after reset and on each power-up
    if (!q.otpLoaded || q.puReq) begin
      d.dbncSel = otp_button_debounce_default;
      d.holdSel = otp_hold_delay_default;
      d.otpLoaded = 1'b1;
    end
    // Hold timer: level mode or released keeps it cleared
    if (!otp_on_pin_mode_cfg || btnLevel) begin
      d.holdMs = '0;
    end else if (q.msTick && (q.holdMs != '1)) begin
      d.holdMs = q.holdMs + 14'd1;
      for (int unsigned i = 0; i < pbs_pkg::N_HOLD; i++) begin
        // Each threshold is crossed once per press
        setv[pbs_pkg::IRQ_HOLD0 + i] = (d.holdMs == pbs_pkg::holdIrqMs(i));
      end
      holdFire = (d.holdMs == pbs_pkg::holdDelayMs(q.holdSel));
    end
    // Press and release only count in system-on states
    setv[pbs_pkg::IRQ_PRESS] = otp_on_pin_mode_cfg && sysOn && btnFell;
    setv[pbs_pkg::IRQ_REL] = otp_on_pin_mode_cfg && sysOn && btnRose;
    // Write one clears; a new event in the same cycle wins
    clrv = wrInt ? regWdata[6:0] : 7'h00;
    d.intr = (q.intr & ~clrv) | setv;
    if (wrMask) begin
      d.mask = regWdata[6:0];
    end
    // Pin pulled low by any unmasked latch
    d.irqN = ~|(d.intr & ~d.mask);
    // Level mode: low holds off, high is only a permission
    d.offHold = !otp_on_pin_mode_cfg && !q.onS2;
    d.lvlOk = !otp_on_pin_mode_cfg && q.onS2;
    d.lvlPrev = q.onS2;
    // Power-on event: debounced press or level rise
    d.onEvt = otp_on_pin_mode_cfg ? btnFell : (q.onS2 && !q.lvlPrev);
    // Long hold without reset enable turns the part off
    d.offEvt = holdFire && !q.rstEn;
    // Standby is the pin xor polarity
    d.stby = q.sbS2 ^ q.stbyPol;
    // Chip reset sequence
    d.puReq = 1'b0;
    case (q.seq)
      pbs_pkg::SEQ_IDLE: begin
        if (holdFire && q.rstEn) begin
          d.seq = pbs_pkg::SEQ_PDOWN;
        end
      end
      pbs_pkg::SEQ_PDOWN: begin
        // Wait for supplies to be sequenced off
        if (powerDownDone) begin
          d.seq = pbs_pkg::SEQ_DISCH;
          d.dischCnt = '0;
        end
      end
      pbs_pkg::SEQ_DISCH: begin
        // Discharge time, counted in raw cycles
        if (q.dischCnt == DISCH_LAST) begin
          d.seq = pbs_pkg::SEQ_PUP;
        end else begin
          d.dischCnt = q.dischCnt + 10'd1;
        end
      end
      pbs_pkg::SEQ_PUP: begin
        // One power-up pulse, then fuse defaults reload
        d.puReq = 1'b1;
        d.seq = pbs_pkg::SEQ_IDLE;
      end
      default: begin
        d.seq = pbs_pkg::SEQ_IDLE;
      end
    endcase
    // Read data only in the cycle after the strobe
    d.rdata = 8'h00;
    if (regRead) begin
      case (regAddr)
        pbs_pkg::ADDR_CTRL: begin
          d.rdata = {2'b00, q.stbyPol, q.rstEn, q.holdSel, q.dbncSel};
        end
        pbs_pkg::ADDR_INT: d.rdata = {1'b0, q.intr};
        pbs_pkg::ADDR_MASK: d.rdata = {1'b0, q.mask};
        pbs_pkg::ADDR_STATUS: begin
          // Sense bit is the inverse of the pin
          d.rdata = {4'h0, !btnLevel, otp_on_pin_mode_cfg, q.stby, !q.onS2};
        end
        default: d.rdata = 8'h00;
      endcase
    end
  end

  // State register; constants only under reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
      q.onS2 <= 1'b1;
      q.onS1 <= 1'b1;
      q.lvlPrev <= 1'b1;
      q.mask <= pbs_pkg::MASK_RST;
      q.irqN <= 1'b1;
      q.seq <= pbs_pkg::SEQ_IDLE;
    end else begin
      q <= d;
    end
  end

  assign regRdata = q.rdata;
  assign irq_out_n = q.irqN;
  assign offModeHold = q.offHold;
  assign powerOnLevelOk = q.lvlOk;
  assign powerOnEvent = q.onEvt;
  assign turnOffReq = q.offEvt;
  assign powerDownReq = (q.seq == pbs_pkg::SEQ_PDOWN);
  assign powerUpReq = q.puReq;
  assign standbyReq = q.stby;

  // Checks on the block's own behaviour
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  property p_level_clear;
    !otp_on_pin_mode_cfg |=> (q.holdMs == 14'd0);
  endproperty
  a_level_clear: assert property (p_level_clear)
    else $error("hold timer runs in level mode");

  property p_level_off;
    (!otp_on_pin_mode_cfg && !q.onS2) |=> (offModeHold && !powerOnLevelOk);
  endproperty
  a_level_off: assert property (p_level_off)
    else $error("level mode low did not hold off");

  property p_edge_event;
    (otp_on_pin_mode_cfg && btnFell) |=> powerOnEvent;
  endproperty
  a_edge_event: assert property (p_edge_event)
    else $error("debounced press gave no power-on event");

  property p_sense;
    (regRead && regAddr == pbs_pkg::ADDR_STATUS) |=>
      (regRdata[0] == !$past(q.onS2));
  endproperty
  a_sense: assert property (p_sense)
    else $error("sense bit not inverse of pin");

  property p_press_latch;
    (otp_on_pin_mode_cfg && sysOn && btnFell) |=> q.intr[pbs_pkg::IRQ_PRESS];
  endproperty
  a_press_latch: assert property (p_press_latch)
    else $error("press latch not set");

  property p_hold_once;
    $rose(q.intr[pbs_pkg::IRQ_HOLD0]) |-> (q.holdMs == pbs_pkg::HOLD_1S_MS);
  endproperty
  a_hold_once: assert property (p_hold_once)
    else $error("one second latch at wrong time");

  property p_turn_off;
    (holdFire && !q.rstEn) |=> (turnOffReq && !powerDownReq);
  endproperty
  a_turn_off: assert property (p_turn_off)
    else $error("hold without reset enable did not turn off");

  property p_discharge;
    (powerDownReq && powerDownDone) |=>
      (q.seq == pbs_pkg::SEQ_DISCH && !powerUpReq) [*8];
  endproperty
  a_discharge: assert property (p_discharge)
    else $error("power-up before discharge wait");

  property p_latch_holds;
    (q.intr[pbs_pkg::IRQ_REL] && !(wrInt && regWdata[pbs_pkg::IRQ_REL])) |=>
      q.intr[pbs_pkg::IRQ_REL];
  endproperty
  a_latch_holds: assert property (p_latch_holds)
    else $error("latch dropped without write one");

  property p_irq_pin;
    irq_out_n == !(|(q.intr & ~q.mask));
  endproperty
  a_irq_pin: assert property (p_irq_pin)
    else $error("interrupt pin disagrees with latches");

  property p_standby;
    ##1 (standbyReq == $past(q.sbS2 ^ q.stbyPol));
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby request not pin xor polarity");

  c_press: cover property (btnFell && sysOn && otp_on_pin_mode_cfg);
  c_turn_off: cover property (turnOffReq);
  c_power_up: cover property (powerUpReq);
  c_standby: cover property ($rose(standbyReq));
endmodule

// >>> tb/pbs_button_host.sv
/*
  Model of the push button and the host pin driving the block.
  Assumes the bench clock; pins change just after rising edges.
*/
`timescale 1ns/1ps
module pbs_button_host (
  input wire logic ref_clk, // Bench clock
  output logic power_on_input, // Button pin, pulled up
  output logic standby_pin // Standby pin from host
);
  // Released button reads high through its pull-up
  initial begin
    power_on_input = 1'b1;
    standby_pin = 1'b0;
  end

  // Pressed button shorts the pin low
  task automatic press();
    @(posedge ref_clk);
    power_on_input <= 1'b0;
  endtask

  // Released button returns to the pull-up level
  task automatic release_btn();
    @(posedge ref_clk);
    power_on_input <= 1'b1;
  endtask

  // Contact shorter than the debounce window
  task automatic bounce(input int n);
    press();
    repeat (n) @(posedge ref_clk);
    release_btn();
  endtask

  // Host drives the raw standby level, polarity is the block's job
  task automatic setStandby(input logic v);
    @(posedge ref_clk);
    standby_pin <= v;
  endtask
endmodule

// >>> tb/test_pbs_button_standby.sv
/*
  Self-checking bench for the button and standby block.
  Assumes MS_CYCLES of 4, so one ms is four clock cycles.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin \
  nTests++; \
  if ((gt) !== (ex)) begin \
    errorCnt++; \
    $display("Error %s exp %0h got %0h", nm, ex, gt); \
  end \
end
module test_pbs_button_standby;
  logic ref_clk = 1'b0; // Bench clock
  logic rst_b = 1'b0; // Reset, active low
  logic otpMode = 1'b1; // Fuse pin mode
  logic sysOn = 1'b1; // System-on state
  logic powerDownDone = 1'b0; // Outside power-down finished
  logic [7:0] regAddr = 8'h00; // Bus address
  logic [7:0] regWdata = 8'h00; // Bus write data
  logic regWrite = 1'b0; // Bus write strobe
  logic regRead = 1'b0; // Bus read strobe
  logic [7:0] regRdata; // Bus read data
  logic irq_out_n, offModeHold, powerOnLevelOk, powerOnEvent; // Outputs
  logic turnOffReq, powerDownReq, powerUpReq, standbyReq; // Outputs
  logic pin, stbyPin; // Pins from the host model
  logic rdPend = 1'b0; // Read data due this cycle
  logic [15:0] expQ[$]; // Mask and expected read data
  logic [15:0] note; // Oldest note
  logic [31:0] seed = 32'h3A6E; // Random state
  int errorCnt = 0; // Mismatches
  int nTests = 0; // Comparisons
  int offCnt = 0; // Turn-off pulses seen
  int n; // Cycles waited
  int lim[4] = '{32, 32, 125, 750}; // Fall debounce per code, ms

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  pbs_button_host i_host (
    .ref_clk(ref_clk),
    .power_on_input(pin),
    .standby_pin(stbyPin)
  );

  pbs_button_standby #(.MS_CYCLES(4)) i_dut (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .power_on_input(pin),
    .standby_pin(stbyPin),
    .otp_on_pin_mode_cfg(otpMode),
    .otp_button_debounce_default(2'b10),
    .otp_hold_delay_default(2'b00),
    .sysOn(sysOn),
    .powerDownDone(powerDownDone),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .irq_out_n(irq_out_n),
    .offModeHold(offModeHold),
    .powerOnLevelOk(powerOnLevelOk),
    .powerOnEvent(powerOnEvent),
    .turnOffReq(turnOffReq),
    .powerDownReq(powerDownReq),
    .powerUpReq(powerUpReq),
    .standbyReq(standbyReq)
  );

  // Read data stand one cycle after the strobe; compare against oldest note
  always @(posedge ref_clk) begin
    if (rdPend) begin
      note = expQ.pop_front();
      `CHK("regRdata", note[7:0], regRdata & note[15:8])
    end
    rdPend <= regRead;
    if (turnOffReq === 1'b1) offCnt++;
  end

  // Xorshift source, fixed start
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // One-cycle write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask

  // One-cycle read; only bits under the mask are compared
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    expQ.push_back({m, e & m});
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
  endtask

  // Watched output by index
  function automatic logic hit(input int w);
    case (w)
      0: return irq_out_n === 1'b0;
      1: return turnOffReq === 1'b1;
      2: return powerDownReq === 1'b1;
      3: return powerUpReq === 1'b1;
      default: return powerOnEvent === 1'b1;
    endcase
  endfunction

  // Bounded wait; running out ends the run as a failure
  task automatic waitFor(input int w, input int bound, output int c);
    c = 0;
    while (c < bound && !hit(w)) begin
      @(posedge ref_clk);
      c++;
    end
    if (c >= bound) begin
      errorCnt++;
      $display("Error wait %0d exp event got none", w);
      reportAndStop();
    end
  endtask

  // Single exit
  task automatic reportAndStop();
    $display("TB: checks %0d errors %0d", nTests, errorCnt);
    if (errorCnt == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK("irq_out_n", 1'b1, irq_out_n)
    rd(pbs_pkg::ADDR_MASK, 8'h7F, 8'hFF);
    rd(pbs_pkg::ADDR_CTRL, 8'h02, 8'hFF);
    rd(8'h10, 8'h00, 8'hFF);
    wr(8'h10, 8'(xs()));
    rd(pbs_pkg::ADDR_CTRL, 8'h02, 8'hFF);
    rd(pbs_pkg::ADDR_STATUS, 8'h04, 8'h05);
    // All pin and polarity pairs
    for (int i = 0; i < 4; i++) begin
      wr(pbs_pkg::ADDR_CTRL, 8'h02 | (i[1] << 5));
      i_host.setStandby(i[0]);
      repeat (5) @(posedge ref_clk);
      `CHK("standbyReq", i[0] ^ i[1], standbyReq)
      rd(pbs_pkg::ADDR_STATUS, 8'({i[0] ^ i[1], 1'b0}), 8'h02);
    end
    wr(pbs_pkg::ADDR_MASK, 8'h00);
    // Every debounce code, with a short bounce first
    for (int c = 0; c < 4; c++) begin
      wr(pbs_pkg::ADDR_CTRL, 8'h0C | c);
      i_host.bounce(int'(xs() % (lim[c] * 4 - 24)) + 1);
      repeat (24) @(posedge ref_clk);
      `CHK("irq_out_n", 1'b1, irq_out_n)
      i_host.press();
      waitFor(0, lim[c] * 4 + 40, n);
      `CHK("pressTime", n >= lim[c]*4-4 && n <= lim[c]*4+12, 1'b1)
      rd(pbs_pkg::ADDR_STATUS, 8'h09, 8'h09);
      if (c == 0) begin
        wr(pbs_pkg::ADDR_MASK, 8'h7F);
        repeat (2) @(posedge ref_clk);
        `CHK("irq_out_n", 1'b1, irq_out_n)
        wr(pbs_pkg::ADDR_MASK, 8'h00);
      end
      i_host.release_btn();
      repeat (150) @(posedge ref_clk);
      rd(pbs_pkg::ADDR_INT, 8'h03, 8'h03);
      wr(pbs_pkg::ADDR_INT, 8'h01);
      rd(pbs_pkg::ADDR_INT, 8'h02, 8'h03);
      wr(pbs_pkg::ADDR_INT, 8'h02);
      repeat (2) @(posedge ref_clk);
      `CHK("irq_out_n", 1'b1, irq_out_n)
    end
    // Outside system-on: power-on event but no press or release latch
    wr(pbs_pkg::ADDR_CTRL, 8'h00);
    sysOn <= 1'b0;
    i_host.press();
    waitFor(4, 200, n);
    i_host.release_btn();
    repeat (150) @(posedge ref_clk);
    rd(pbs_pkg::ADDR_INT, 8'h00, 8'h03);
    sysOn <= 1'b1;
    // Long hold, reset disabled, 2 s delay
    i_host.press();
    waitFor(1, 8400, n);
    `CHK("offTime", n >= 8120 && n <= 8160, 1'b1)
    repeat (24200) @(posedge ref_clk);
    rd(pbs_pkg::ADDR_INT, 8'h7D, 8'h7F);
    i_host.release_btn();
    repeat (150) @(posedge ref_clk);
    rd(pbs_pkg::ADDR_INT, 8'h7F, 8'h7F);
    `CHK("offCnt", 1, offCnt)
    wr(pbs_pkg::ADDR_INT, 8'h7F);
    repeat (2) @(posedge ref_clk);
    `CHK("irq_out_n", 1'b1, irq_out_n)
    // Long hold, reset enabled: power down, discharge, power up
    wr(pbs_pkg::ADDR_CTRL, 8'h10);
    i_host.press();
    waitFor(2, 8400, n);
    i_host.release_btn();
    repeat (int'(xs() % 16) + 1) @(posedge ref_clk);
    powerDownDone <= 1'b1;
    waitFor(3, 700, n);
    `CHK("dischTime", n >= 598 && n <= 606, 1'b1)
    powerDownDone <= 1'b0;
    `CHK("offCnt", 1, offCnt)
    repeat (4) @(posedge ref_clk);
    rd(pbs_pkg::ADDR_CTRL, 8'h02, 8'h0F);
    // Read data must be compared before reset clears them
    @(posedge ref_clk);
    // Level mode after a second reset
    otpMode <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    i_host.press();
    repeat (5) @(posedge ref_clk);
    `CHK("offModeHold", 1'b1, offModeHold)
    i_host.release_btn();
    // Level rise gives a power-on event three edges after the pin
    waitFor(4, 8, n);
    `CHK("powerOnLevelOk", 1'b1, powerOnLevelOk)
    `CHK("offModeHold", 1'b0, offModeHold)
    rd(pbs_pkg::ADDR_STATUS, 8'h00, 8'h04);
    repeat (2) @(posedge ref_clk);
    reportAndStop();
  end
endmodule
